// ---- core/pfs_pkg.sv ----
// Constants and types of the pin function select block
// Overview of operation
// R1 - Only power-on reset loads the reset-pin enable default; other resets keep it.
// R2 - While the reset-pin enable is set, the reset pad pull-up is on.
// R3 - Reset-pin enable 0 gives the shared pad its port function; 1 makes it reset.
// R4 - Reset-pin enable takes one write after any reset; later writes ignored.
// R5 - Interrupt-pin enable takes one write after any reset; later writes ignored.
// R6 - Of the resets, only power-on reset makes the shared pad the unmaskable interrupt input.
// R7 - While the interrupt-pin enable is set, the interrupt pad pull-up is on.
// R8 - Interrupt-pin enable 0 gives the pad other functions; 1 makes it the interrupt.
// R9 - Reserved bits of both registers are read-only and read as zero.
// R10 - Bit 31 picks timer clock input a (0) or b (1) for the pulse-width timer.
// R11 - Bit 30 picks timer clock input a (0) or b (1) for flex timer two.
// R12 - Bit 28 picks timer clock input a (0) or b (1) for flex timer zero.
// R13 - Bit 15 puts flex timer two channel 3 on port C3 or C5.
// R14 - Bit 14 puts flex timer two channel 2 on port C2 or C4.
// R15 - Bit 9 puts flex timer zero channel 1 on port A1 or B3.
// R16 - Bit 8 puts flex timer zero channel 0 on port A0 or B2.
// R17 - Bit 7 puts serial receive and transmit on B0/B1 or A2/A3.
// R18 - Bit 6 puts SPI lines on B2 to B5, or A6, A7, B1, B0.
// R19 - Bit 5 puts I2C clock and data on A3/A2 or B7/B6.
// R20 - Pad routing follows stored bits from the clock edge after the write.
package pfs_pkg;
   localparam int PFS_AW = 8;
   localparam logic [7:0] PFS_OFF_OPT = 8'h00;
   localparam logic [7:0] PFS_OFF_SEL = 8'h04;
   localparam int PFS_RST_PIN_BIT = 2;
   localparam int PFS_NMI_PIN_BIT = 1;
   localparam int PFS_PW_TIMER_CLK_BIT = 31;
   localparam int PFS_FT2_CLK_BIT = 30;
   localparam int PFS_FT0_CLK_BIT = 28;
   localparam int PFS_FT2_CH3_BIT = 15;
   localparam int PFS_FT2_CH2_BIT = 14;
   localparam int PFS_FT0_CH1_BIT = 9;
   localparam int PFS_FT0_CH0_BIT = 8;
   localparam int PFS_UART_BIT = 7;
   localparam int PFS_SPI_BIT = 6;
   localparam int PFS_I2C_BIT = 5;
   localparam logic [31:0] PFS_OPT_MASK = 32'h0000_0006;
   localparam logic [31:0] PFS_SEL_MASK = 32'hD000_C3E0;
   localparam logic [31:0] PFS_SEL_RESET = 32'h0000_0000;
   localparam logic PFS_RST_PIN_POR = 1'b1;
   localparam logic PFS_NMI_PIN_POR = 1'b1;
   localparam int PFS_PAD_RST = 0;
   localparam int PFS_PAD_NMI = 1;
   localparam int PFS_PAD_TCA = 2;
   localparam int PFS_PAD_TCB = 3;
   localparam logic [3:0] PFS_PAD_IDLE = 4'h3;

   typedef struct packed {
      logic reset_pin_is_reset;
      logic reset_pin_pullup;
      logic nmi_pin_is_nmi;
      logic nmi_pin_pullup;
      logic flex_timer_two_ch3_on_pc3;
      logic flex_timer_two_ch3_on_pc5;
      logic flex_timer_two_ch2_on_pc2;
      logic flex_timer_two_ch2_on_pc4;
      logic flex_timer_zero_ch1_on_pa1;
      logic flex_timer_zero_ch1_on_pb3;
      logic flex_timer_zero_ch0_on_pa0;
      logic flex_timer_zero_ch0_on_pb2;
      logic uart_on_pb0_pb1;
      logic uart_on_pa2_pa3;
      logic spi_on_pb2_pb5;
      logic spi_on_pa6_pa7_pb1_pb0;
      logic i2c_on_pa3_pa2;
      logic i2c_on_pb7_pb6;
   } pfs_route_s;

   typedef struct packed {
      logic pulse_width_timer_clk;
      logic flex_timer_two_clk;
      logic flex_timer_zero_clk;
   } pfs_tclk_s;

   typedef struct packed {
      logic opt_written;
      logic rst_pin_en;
      logic nmi_pin_en;
      logic [31:0] sel;
      logic [3:0] sy1;
      logic [3:0] sy2;
      logic [3:0] sy3;
      logic [3:0] lvl;
      pfs_route_s route;
      pfs_tclk_s tclk;
      logic reset_req;
      logic nmi_req;
      logic [31:0] rdata;
   } pfs_state_s;
endpackage

// ---- core/pfs_pin_function_select.sv ----
// Pin function select: option pin enables, peripheral pin routing
`timescale 1ns/10ps
module pfs_pin_function_select (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic por_reset,
   // Register port
   input wire logic [pfs_pkg::PFS_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Pad levels
   input wire logic reset_pad_n,
   input wire logic nmi_pad_n,
   input wire logic external_timer_clock_a,
   input wire logic external_timer_clock_b,
   // Pad multiplexer controls
   output pfs_pkg::pfs_route_s pad_route,
   // Timer clocks
   output pfs_pkg::pfs_tclk_s timer_clk,
   // Requests from shared pads
   output logic reset_request,
   output logic nmi_request
);
   import pfs_pkg::*;

   pfs_state_s st;
   pfs_state_s next_st;

   // Address match for one register
   function automatic logic pfs_hit(
      input logic [PFS_AW-1:0] addr,
      input logic [PFS_AW-1:0] off
   );
      pfs_hit = (addr == off);
   endfunction

   // Pad multiplexer decode
   function automatic pfs_route_s pfs_route(
      input logic [31:0] sel,
      input logic rst_en,
      input logic nmi_en
   );
      pfs_route_s r;
      r = '0;
      // R3 reset pad function
      r.reset_pin_is_reset = rst_en;
      // R2 reset pad pullup
      r.reset_pin_pullup = rst_en;
      // R8 interrupt pad function
      r.nmi_pin_is_nmi = nmi_en;
      // R7 interrupt pad pullup
      r.nmi_pin_pullup = nmi_en;
      // R13 channel three pad
      r.flex_timer_two_ch3_on_pc3 = !sel[PFS_FT2_CH3_BIT];
      r.flex_timer_two_ch3_on_pc5 = sel[PFS_FT2_CH3_BIT];
      // R14 channel two pad
      r.flex_timer_two_ch2_on_pc2 = !sel[PFS_FT2_CH2_BIT];
      r.flex_timer_two_ch2_on_pc4 = sel[PFS_FT2_CH2_BIT];
      // R15 channel one pad
      r.flex_timer_zero_ch1_on_pa1 = !sel[PFS_FT0_CH1_BIT];
      r.flex_timer_zero_ch1_on_pb3 = sel[PFS_FT0_CH1_BIT];
      // R16 channel zero pad
      r.flex_timer_zero_ch0_on_pa0 = !sel[PFS_FT0_CH0_BIT];
      r.flex_timer_zero_ch0_on_pb2 = sel[PFS_FT0_CH0_BIT];
      // R17 serial port pads
      r.uart_on_pb0_pb1 = !sel[PFS_UART_BIT];
      r.uart_on_pa2_pa3 = sel[PFS_UART_BIT];
      // R18 SPI pads
      r.spi_on_pb2_pb5 = !sel[PFS_SPI_BIT];
      r.spi_on_pa6_pa7_pb1_pb0 = sel[PFS_SPI_BIT];
      // R19 I2C pads
      r.i2c_on_pa3_pa2 = !sel[PFS_I2C_BIT];
      r.i2c_on_pb7_pb6 = sel[PFS_I2C_BIT];
      pfs_route = r;
   endfunction

   // Timer clock pad choice
   function automatic logic pfs_clk_pick(
      input logic pick_b,
      input logic [3:0] lvl
   );
      pfs_clk_pick = pick_b ? lvl[PFS_PAD_TCB] : lvl[PFS_PAD_TCA];
   endfunction

   // Next state
   always_comb begin
      next_st = st;

      // Pad synchronisers
      next_st.sy1 = {external_timer_clock_b, external_timer_clock_a, nmi_pad_n, reset_pad_n};
      next_st.sy2 = st.sy1;
      next_st.sy3 = st.sy2;
      for (int i = 0; i < 4; i++) begin
         if (st.sy2[i] == st.sy3[i]) begin
            next_st.lvl[i] = st.sy3[i];
         end
      end

      // R4 first option write
      // R5 first option write
      if (reg_wr && pfs_hit(reg_addr, PFS_OFF_OPT) && !st.opt_written) begin
         next_st.rst_pin_en = reg_wdata[PFS_RST_PIN_BIT];
         next_st.nmi_pin_en = reg_wdata[PFS_NMI_PIN_BIT];
         next_st.opt_written = 1'b1;
      end

      // R9 reserved bits dropped
      if (reg_wr && pfs_hit(reg_addr, PFS_OFF_SEL)) begin
         next_st.sel = reg_wdata & PFS_SEL_MASK;
      end

      // Read data for one cycle
      next_st.rdata = '0;
      if (reg_rd) begin
         if (pfs_hit(reg_addr, PFS_OFF_OPT)) begin
            next_st.rdata[PFS_RST_PIN_BIT] = st.rst_pin_en;
            next_st.rdata[PFS_NMI_PIN_BIT] = st.nmi_pin_en;
         end else if (pfs_hit(reg_addr, PFS_OFF_SEL)) begin
            next_st.rdata = st.sel & PFS_SEL_MASK;
         end
      end

      // R3 external reset request
      next_st.reset_req = st.rst_pin_en && !st.lvl[PFS_PAD_RST];
      // R8 interrupt request
      next_st.nmi_req = st.nmi_pin_en && !st.lvl[PFS_PAD_NMI];

      // R1 power-on default only
      // R6 power-on default only
      if (sys_rst) begin
         next_st = '0;
         next_st.sel = PFS_SEL_RESET;
         next_st.sy1 = PFS_PAD_IDLE;
         next_st.sy2 = PFS_PAD_IDLE;
         next_st.sy3 = PFS_PAD_IDLE;
         next_st.lvl = PFS_PAD_IDLE;
         next_st.rst_pin_en = por_reset ? PFS_RST_PIN_POR : st.rst_pin_en;
         next_st.nmi_pin_en = por_reset ? PFS_NMI_PIN_POR : st.nmi_pin_en;
      end

      // R10 pulse-width timer clock
      next_st.tclk.pulse_width_timer_clk =
         pfs_clk_pick(next_st.sel[PFS_PW_TIMER_CLK_BIT], st.lvl);
      // R11 timer two clock
      next_st.tclk.flex_timer_two_clk =
         pfs_clk_pick(next_st.sel[PFS_FT2_CLK_BIT], st.lvl);
      // R12 timer zero clock
      next_st.tclk.flex_timer_zero_clk =
         pfs_clk_pick(next_st.sel[PFS_FT0_CLK_BIT], st.lvl);
      if (sys_rst) begin
         next_st.tclk = '0;
      end

      // R20 route from new bits
      next_st.route = pfs_route(next_st.sel, next_st.rst_pin_en, next_st.nmi_pin_en);
   end

   // State register
   always_ff @(posedge clk_sys) begin
      st <= next_st;
   end

   assign reg_rdata = st.rdata;
   assign pad_route = st.route;
   assign timer_clk = st.tclk;
   assign reset_request = st.reset_req;
   assign nmi_request = st.nmi_req;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_opt_wr;
      reg_wr && pfs_hit(reg_addr, PFS_OFF_OPT);
   endsequence

   sequence s_sel_wr;
      reg_wr && pfs_hit(reg_addr, PFS_OFF_SEL);
   endsequence

   sequence s_first_opt_wr;
      !st.opt_written ##0 s_opt_wr;
   endsequence

   sequence s_sel_rd;
      reg_rd && pfs_hit(reg_addr, PFS_OFF_SEL);
   endsequence

   sequence s_other_rd;
      reg_rd && !pfs_hit(reg_addr, PFS_OFF_OPT) && !pfs_hit(reg_addr, PFS_OFF_SEL);
   endsequence

   sequence s_rst_pad_low;
      st.rst_pin_en && !st.lvl[PFS_PAD_RST];
   endsequence

   sequence s_nmi_pad_low;
      st.nmi_pin_en && !st.lvl[PFS_PAD_NMI];
   endsequence

   // R1 reset pin default
   a_rst_pin_por: assert property ( // R1
      $fell(sys_rst) |->
         st.rst_pin_en == ($past(por_reset) ? PFS_RST_PIN_POR : $past(st.rst_pin_en)))
      else $error("reset pad enable wrong after reset");

   // R6 interrupt pin default
   a_nmi_pin_por: assert property ( // R6
      $fell(sys_rst) |->
         st.nmi_pin_en == ($past(por_reset) ? PFS_NMI_PIN_POR : $past(st.nmi_pin_en)))
      else $error("interrupt pad enable wrong after reset");

   // R2 reset pad pullup
   a_reset_pullup: assert property ( // R2
      ##1 st.route.reset_pin_pullup == st.rst_pin_en)
      else $error("reset pad pullup does not follow enable");

   // R3 reset request path
   a_reset_req: assert property ( // R3
      st.reset_req |-> $past(st.rst_pin_en) && !$past(st.lvl[PFS_PAD_RST]))
      else $error("reset request without reset pad function");

   // R4 later writes ignored
   a_opt_locked: assert property ( // R4
      st.opt_written && reg_wr && pfs_hit(reg_addr, PFS_OFF_OPT) |=>
         $stable(st.rst_pin_en) && $stable(st.nmi_pin_en))
      else $error("option enables changed after first write");

   // R5 first write taken
   a_opt_first: assert property ( // R5
      s_first_opt_wr |=>
         st.opt_written && st.nmi_pin_en == $past(reg_wdata[PFS_NMI_PIN_BIT])
         && st.rst_pin_en == $past(reg_wdata[PFS_RST_PIN_BIT]))
      else $error("first option write not taken");

   // R7 interrupt pad pullup
   a_nmi_pullup: assert property ( // R7
      $changed(st.nmi_pin_en) |-> st.route.nmi_pin_pullup == st.nmi_pin_en)
      else $error("interrupt pad pullup does not follow enable");

   // R8 interrupt request path
   a_nmi_req: assert property ( // R8
      !st.nmi_pin_en [*2] |-> !st.nmi_req)
      else $error("interrupt request while pad not interrupt");

   // R9 reserved reads zero
   a_resv_zero: assert property ( // R9
      reg_rd && pfs_hit(reg_addr, PFS_OFF_OPT) |=> (st.rdata & ~PFS_OPT_MASK) == 32'h0)
      else $error("reserved option bits read nonzero");

   // R10 pulse-width clock source
   a_pw_timer_clk: assert property ( // R10
      ##1 st.tclk.pulse_width_timer_clk == (st.sel[PFS_PW_TIMER_CLK_BIT] ?
         $past(st.lvl[PFS_PAD_TCB]) : $past(st.lvl[PFS_PAD_TCA])))
      else $error("pulse-width timer clock from wrong pad");

   // R17 serial pads follow write
   a_uart_route: assert property ( // R17
      s_sel_wr |=> st.route.uart_on_pa2_pa3 == $past(reg_wdata[PFS_UART_BIT])
         && st.route.uart_on_pb0_pb1 != st.route.uart_on_pa2_pa3)
      else $error("serial pads do not follow selection");

   // R20 routing one edge later
   a_route_timing: assert property ( // R20
      s_sel_wr ##1 !reg_wr [*2] |->
         $stable(st.route) && st.route.spi_on_pa6_pa7_pb1_pb0 == st.sel[PFS_SPI_BIT])
      else $error("routing not settled after write");

   // R11 timer two clock source
   a_ft2_clk_src: assert property ( // R11
      ##1 st.tclk.flex_timer_two_clk == (st.sel[PFS_FT2_CLK_BIT] ?
         $past(st.lvl[PFS_PAD_TCB]) : $past(st.lvl[PFS_PAD_TCA])))
      else $error("flex timer two clock from wrong pad");

   // R12 timer zero clock source
   a_ft0_clk_src: assert property ( // R12
      ##1 st.tclk.flex_timer_zero_clk == (st.sel[PFS_FT0_CLK_BIT] ?
         $past(st.lvl[PFS_PAD_TCB]) : $past(st.lvl[PFS_PAD_TCA])))
      else $error("flex timer zero clock from wrong pad");

   // R13 channel three pads
   a_ch3_route: assert property ( // R13
      s_sel_wr |=> st.route.flex_timer_two_ch3_on_pc5 == $past(reg_wdata[PFS_FT2_CH3_BIT])
         && st.route.flex_timer_two_ch3_on_pc3 != st.route.flex_timer_two_ch3_on_pc5)
      else $error("timer two channel three pads do not follow selection");

   // R14 channel two pads
   a_ch2_route: assert property ( // R14
      s_sel_wr |=> st.route.flex_timer_two_ch2_on_pc4 == $past(reg_wdata[PFS_FT2_CH2_BIT])
         && st.route.flex_timer_two_ch2_on_pc2 != st.route.flex_timer_two_ch2_on_pc4)
      else $error("timer two channel two pads do not follow selection");

   // R15 channel one pads
   a_ch1_route: assert property ( // R15
      s_sel_wr |=> st.route.flex_timer_zero_ch1_on_pb3 == $past(reg_wdata[PFS_FT0_CH1_BIT])
         && st.route.flex_timer_zero_ch1_on_pa1 != st.route.flex_timer_zero_ch1_on_pb3)
      else $error("timer zero channel one pads do not follow selection");

   // R16 channel zero pads
   a_ch0_route: assert property ( // R16
      s_sel_wr |=> st.route.flex_timer_zero_ch0_on_pb2 == $past(reg_wdata[PFS_FT0_CH0_BIT])
         && st.route.flex_timer_zero_ch0_on_pa0 != st.route.flex_timer_zero_ch0_on_pb2)
      else $error("timer zero channel zero pads do not follow selection");

   // R18 SPI pads follow write
   a_spi_route: assert property ( // R18
      s_sel_wr |=> st.route.spi_on_pa6_pa7_pb1_pb0 == $past(reg_wdata[PFS_SPI_BIT])
         && st.route.spi_on_pb2_pb5 != st.route.spi_on_pa6_pa7_pb1_pb0)
      else $error("SPI pads do not follow selection");

   // R19 I2C pads follow write
   a_i2c_route: assert property ( // R19
      s_sel_wr |=> st.route.i2c_on_pb7_pb6 == $past(reg_wdata[PFS_I2C_BIT])
         && st.route.i2c_on_pa3_pa2 != st.route.i2c_on_pb7_pb6)
      else $error("I2C pads do not follow selection");

   // R3 reset pad function
   a_reset_pad_func: assert property ( // R3
      $changed(st.rst_pin_en) |-> st.route.reset_pin_is_reset == st.rst_pin_en)
      else $error("reset pad function does not follow enable");

   // R8 interrupt pad function
   a_nmi_pad_func: assert property ( // R8
      $changed(st.nmi_pin_en) |-> st.route.nmi_pin_is_nmi == st.nmi_pin_en)
      else $error("interrupt pad function does not follow enable");

   // R4 first write locks
   a_opt_lock_set: assert property ( // R4
      s_opt_wr |=> st.opt_written)
      else $error("option write did not lock the enables");

   // R9 selection reserved zero
   a_sel_resv_zero: assert property ( // R9
      s_sel_rd |=> (st.rdata & ~PFS_SEL_MASK) == 32'h0)
      else $error("reserved selection bits read nonzero");

   // R9 unmapped reads zero
   a_unmapped_zero: assert property ( // R9
      s_other_rd |=> st.rdata == 32'h0)
      else $error("unmapped address read nonzero");

   // R9 idle read data
   a_rdata_idle: assert property ( // R9
      !reg_rd |=> st.rdata == 32'h0)
      else $error("read data nonzero without read");

   // R20 selection stored
   a_sel_stored: assert property ( // R20
      s_sel_wr |=> st.sel == ($past(reg_wdata) & PFS_SEL_MASK))
      else $error("selection not stored from write");

   // R3 reset request raised
   a_reset_req_set: assert property ( // R3
      s_rst_pad_low |=> st.reset_req)
      else $error("reset request missing with pad low");

   // R8 interrupt request raised
   a_nmi_req_set: assert property ( // R8
      s_nmi_pad_low |=> st.nmi_req)
      else $error("interrupt request missing with pad low");

   // R20 serial, SPI and I2C pad pairs one-hot
   a_route_pairs: assert property ( // R20
      ##1 st.route.uart_on_pb0_pb1 != st.route.uart_on_pa2_pa3
         && st.route.spi_on_pb2_pb5 != st.route.spi_on_pa6_pa7_pb1_pb0
         && st.route.i2c_on_pa3_pa2 != st.route.i2c_on_pb7_pb6)
      else $error("pad pair selects both or neither");

   // R1 other reset keeps enable
   a_rst_pin_keep: assert property ( // R1
      $fell(sys_rst) && !$past(por_reset) |-> $stable(st.rst_pin_en))
      else $error("reset pad enable changed by other reset");

endmodule // pfs_pin_function_select

// ---- verification/pfs_pin_function_select_tb.sv ----
// Self-checking testbench of the pin function select block
`timescale 1ns/10ps
module pfs_pin_function_select_tb;
   import pfs_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic por_reset = 1'b1;
   logic [PFS_AW-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic reset_pad_n = 1'b1;
   logic nmi_pad_n = 1'b1;
   logic tca = 1'b0;
   logic tcb = 1'b0;
   pfs_route_s pad_route;
   pfs_tclk_s timer_clk;
   logic reset_request;
   logic nmi_request;
   int mismatches = 0;
   int tests_run = 0;
   logic [31:0] s;
   int bits [8] = '{15, 14, 9, 8, 7, 6, 5, 31};

   pfs_pin_function_select DUT (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .por_reset(por_reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reset_pad_n(reset_pad_n), .nmi_pad_n(nmi_pad_n),
      .external_timer_clock_a(tca), .external_timer_clock_b(tcb),
      .pad_route(pad_route), .timer_clk(timer_clk),
      .reset_request(reset_request), .nmi_request(nmi_request));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      v = reg_rdata;
   endtask

   task automatic do_reset(input logic por);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      por_reset <= por;
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      por_reset <= 1'b0;
   endtask

   task automatic chk_route(input logic [31:0] x, input logic r, input logic n);
      pfs_route_s e;
      @(posedge clk_sys);
      e = '{r, r, n, n, ~x[15], x[15], ~x[14], x[14], ~x[9], x[9], ~x[8], x[8],
            ~x[7], x[7], ~x[6], x[6], ~x[5], x[5]};
      chk(32'(pad_route), 32'(e), "pad route");
   endtask

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e, "register read");
   endtask

   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      mismatches++;
      finish_test();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      por_reset <= 1'b0;
      chk_reg(PFS_OFF_OPT, 32'h0000_0006);
      chk_route(32'h0, 1'b1, 1'b1);
      reset_pad_n <= 1'b0;
      nmi_pad_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({reset_request, nmi_request}, 32'h3, "pad requests");
      reset_pad_n <= 1'b1;
      nmi_pad_n <= 1'b1;
      // Timer clock source per selection bit
      tca <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         s = (i == 0) ? 32'h0 : (i == 1) ? 32'h8000_0000 : (i == 2) ? 32'h4000_0000 : 32'h1000_0000;
         wr(PFS_OFF_SEL, s);
         repeat (8) @(posedge clk_sys);
         chk(32'(timer_clk), {29'h0, ~s[31], ~s[30], ~s[28]}, "timer clocks");
      end
      // Each routing bit alone, checked at the edge after its write edge
      foreach (bits[i]) begin
         s = 32'h1 << bits[i];
         wr(PFS_OFF_SEL, s);
         chk_route(s, 1'b1, 1'b1);
      end
      wr(PFS_OFF_SEL, 32'hFFFF_FFFF);
      chk_route(32'hFFFF_FFFF, 1'b1, 1'b1);
      chk_reg(PFS_OFF_SEL, 32'hD000_C3E0);
      wr(8'h08, 32'h0);
      chk_reg(8'h08, 32'h0);
      chk_reg(PFS_OFF_SEL, 32'hD000_C3E0);
      // Option write clears both enables, then is locked
      wr(PFS_OFF_OPT, 32'h0);
      chk_route(32'hFFFF_FFFF, 1'b0, 1'b0);
      wr(PFS_OFF_OPT, 32'hFFFF_FFFF);
      chk_reg(PFS_OFF_OPT, 32'h0);
      reset_pad_n <= 1'b0;
      nmi_pad_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({reset_request, nmi_request}, 32'h0, "masked requests");
      reset_pad_n <= 1'b1;
      nmi_pad_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      // Other reset keeps enables, unlocks one more write
      do_reset(1'b0);
      chk_reg(PFS_OFF_OPT, 32'h0);
      chk_reg(PFS_OFF_SEL, 32'h0);
      wr(PFS_OFF_OPT, 32'h0000_0004);
      chk_route(32'h0, 1'b1, 1'b0);
      wr(PFS_OFF_OPT, 32'h0000_0002);
      chk_reg(PFS_OFF_OPT, 32'h0000_0004);
      do_reset(1'b0);
      chk_reg(PFS_OFF_OPT, 32'h0000_0004);
      wr(PFS_OFF_OPT, 32'h0000_0002);
      chk_reg(PFS_OFF_OPT, 32'h0000_0002);
      do_reset(1'b1);
      chk_reg(PFS_OFF_OPT, 32'h0000_0006);
      finish_test();
   end
endmodule // pfs_pin_function_select_tb
